// ### i2ca_consts.vh
/*
  Register offsets, field positions and reset values of the i2c arbitration
  block. Assumes a byte-addressed APB bus, one aligned 32-bit word a register.
*/
`ifndef I2CA_CONSTS_VH
`define I2CA_CONSTS_VH

// ==========================================================================
// register byte offsets
`define I2CA_OFF_BAUD  8'h00
`define I2CA_OFF_BUF   8'h04
`define I2CA_OFF_CTL1  8'h08
`define I2CA_OFF_CTL2  8'h0C
`define I2CA_OFF_CTL3  8'h10
`define I2CA_OFF_MASK  8'h14
`define I2CA_OFF_STAT  8'h18
`define I2CA_OFF_IEN1  8'h1C
`define I2CA_OFF_IEN2  8'h20
`define I2CA_OFF_IFL1  8'h24
`define I2CA_OFF_IFL2  8'h28

// ==========================================================================
// field positions
`define I2CA_B_WRITE_COLLISION_FLAG    7
`define I2CA_B_EN      5
`define I2CA_B_ACKSTAT 6
`define I2CA_B_ACKDT   5
`define I2CA_B_ACK_SEQ_ENABLE   4
`define I2CA_B_PEN     2
`define I2CA_B_RESTART_SEQ_ENABLE    1
`define I2CA_B_SEN     0
`define I2CA_B_STOP    4
`define I2CA_B_START   3
`define I2CA_B_BF      0
`define I2CA_B_IRQ     3

// ==========================================================================
// mode code, reset values and ack bit index
`define I2CA_MODE_MASTER 4'h8
`define I2CA_RST_BYTE    8'h00
`define I2CA_RST_MASK    8'hFF
`define I2CA_ACK_BIT     4'h8

`endif

// ### i2ca_sync.v
/*
  Two-flop synchroniser, one chain per bit.
  Assumes inputs are asynchronous to clk; output is safe to use in clk domain.
*/
`default_nettype none

module i2ca_sync #(
  parameter W = 2
) (
  // clock
  input  wire         clk,
  // async in, synced out
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  // ========================================================================
  // per-bit two-stage chain
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // first stage feeds only the second
      always @(posedge clk) begin
        meta_q <= d[i];
        sync_q <= meta_q;
      end
      assign q[i] = sync_q;
    end
  endgenerate

endmodule

`default_nettype wire

// ### i2ca_top.v
/*
  I2C master with bus arbitration and collision detection, bus-free tracking,
  a small slave receiver that can wake a sleeping processor, and APB registers.
  Assumes open-drain SDA/SCL resolved outside; 20 MHz CLK; pins are async.
*/
// The APB slave port and the placing of the registers were decided locally.
// Operation
// - buffer write during a running sequence sets write collision, write dropped
// - slave keeps receiving in sleep, wakes on match or byte
// - reset disables the port and abandons any transfer
// - stop and start bits clear on reset or port disable
// - busy bus, stop detected raises the port interrupt
// - compare SDA with intended output, report loss in collision flag
// - released SDA sampled low with SCL high is a collision
// - byte collision stops sending, clears full flag, releases lines
// - condition collision aborts, releases lines, clears sequence enables
// - after collision keep watching, stop sets port interrupt flag
// - next buffer write after collision starts from first bit
// - start with SDA or SCL already low is a collision
// - start: SDA high runs counter, SCL low then is collision
// - start: SDA low during count drives SDA low early
// - start: SDA low at count end, recount, then SCL low
// - restart: release SDA, count, release SCL, SDA low is collision
// - restart: SDA high reloads counter, SDA fall is no collision
// - restart: SCL falls before timeout, SDA undriven, is collision
// - restart: both high at timeout, SDA low, count, SCL low
// - stop: SDA low seen, release SCL, count, SDA low is collision
// - stop: SCL low before SDA floats is collision
// - stop: SDA high with SCL high sets stop bit, period later interrupt
`default_nettype none
`include "i2ca_consts.vh"

module i2ca_top #(
  parameter AW = 8
) (
  // clock and reset
  input  wire          CLK,
  input  wire          SRST,
  // apb slave
  input  wire          PSEL,
  input  wire          PENABLE,
  input  wire          PWRITE,
  input  wire [AW-1:0] PADDR,
  input  wire [31:0]   PWDATA,
  output reg  [31:0]   PRDATA,
  output reg           PREADY,
  output reg           PSLVERR,
  // i2c open-drain pins
  input  wire          SCL_IN,
  output reg           SCL_OUT,
  output reg           SCL_OE,
  input  wire          SDA_IN,
  output reg           SDA_OUT,
  output reg           SDA_OE,
  // system
  input  wire          SLEEP,
  output reg           PORT_IRQ,
  output reg           WAKE
);

  // ========================================================================
  // states
  localparam [3:0] ST_IDLE = 4'h0, ST_S_WAIT = 4'h1, ST_S_HOLD = 4'h2;
  localparam [3:0] ST_R_LOW = 4'h3, ST_R_HIGH = 4'h4, ST_R_HOLD = 4'h5;
  localparam [3:0] ST_P_LOW = 4'h6, ST_P_HIGH = 4'h7, ST_P_REL = 4'h8;
  localparam [3:0] ST_P_END = 4'h9, ST_T_LOW = 4'hA, ST_T_HIGH = 4'hB;
  localparam [3:0] ST_A_LOW = 4'hC, ST_A_HIGH = 4'hD;

  // ========================================================================
  // state
  reg  [7:0] baud_q, buf_q, ctl3_q, mask_q, sh_q, ssh_q, cnt_q;
  reg  [3:0] mode_q, st_q, idx_q, sbit_q;
  reg        en_q, write_collision_flag_q, ackstat_q, ackdt_q;
  reg        sen_q, restart_seq_enable_q, pen_q, ack_seq_enable_q;
  reg        bf_q, stop_q, start_q, pie_q, bie_q, pif_q, bcl_q;
  reg        seen_q, sfirst_q, sact_q, scl_p_q, sda_p_q;
  reg        coll_d;
  reg  [7:0] rdata;
  reg        hit;
  wire [1:0] pin_s;
  wire       scl = pin_s[1];
  wire       sda = pin_s[0];

  // pins pass two flops before use
  i2ca_sync #(.W(2)) u_sync (
    .clk (CLK),
    .d   ({SCL_IN, SDA_IN}),
    .q   (pin_s)
  );

  // ========================================================================
  // bus events
  wire master    = (mode_q == `I2CA_MODE_MASTER);
  wire start_det = scl & scl_p_q & sda_p_q & ~sda;
  wire stop_det  = scl & scl_p_q & ~sda_p_q & sda;
  wire scl_rise  = scl & ~scl_p_q;
  wire tick      = (cnt_q == `I2CA_RST_BYTE);
  wire own_stop  = (st_q == ST_P_REL) | (st_q == ST_P_END);
  wire addr_hit  = (((ssh_q ^ baud_q) & mask_q & 8'hFE) == 8'h00);

  // ========================================================================
  // apb decode
  wire setup  = PSEL & ~PENABLE;
  wire wr     = PSEL & PENABLE & PREADY & PWRITE;
  wire rd     = PSEL & PENABLE & PREADY & ~PWRITE;
  wire [7:0] a = PADDR[7:0];
  wire wr_buf = wr & (a == `I2CA_OFF_BUF);
  wire wr_c1  = wr & (a == `I2CA_OFF_CTL1);
  wire wr_c2  = wr & (a == `I2CA_OFF_CTL2);
  wire wr_f1  = wr & (a == `I2CA_OFF_IFL1);
  wire wr_f2  = wr & (a == `I2CA_OFF_IFL2);
  wire rd_buf = rd & (a == `I2CA_OFF_BUF);

  // read mux and unmapped detect
  always @* begin
    hit = 1'b1;
    if (a == `I2CA_OFF_BAUD) rdata = baud_q;
    else if (a == `I2CA_OFF_BUF) rdata = buf_q;
    else if (a == `I2CA_OFF_CTL1) rdata = {write_collision_flag_q, 1'b0, en_q, 1'b0, mode_q};
    else if (a == `I2CA_OFF_CTL2)
      rdata = {1'b0, ackstat_q, ackdt_q, ack_seq_enable_q, 1'b0, pen_q, restart_seq_enable_q, sen_q};
    else if (a == `I2CA_OFF_CTL3) rdata = ctl3_q;
    else if (a == `I2CA_OFF_MASK) rdata = mask_q;
    else if (a == `I2CA_OFF_STAT) rdata = {3'b000, stop_q, start_q, 2'b00, bf_q};
    else if (a == `I2CA_OFF_IEN1) rdata = {4'h0, pie_q, 3'b000};
    else if (a == `I2CA_OFF_IEN2) rdata = {4'h0, bie_q, 3'b000};
    else if (a == `I2CA_OFF_IFL1) rdata = {4'h0, pif_q, 3'b000};
    else if (a == `I2CA_OFF_IFL2) rdata = {4'h0, bcl_q, 3'b000};
    else begin
      rdata = 8'h00;
      hit = 1'b0;
    end
  end

  // no-wait-state apb answer: ready in the first access cycle
  always @(posedge CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PRDATA  <= setup ? {24'h000000, rdata} : 32'h00000000;
      PSLVERR <= setup & ~hit;
    end
  end

  // plain configuration registers
  always @(posedge CLK) begin
    if (SRST) begin
      baud_q  <= `I2CA_RST_BYTE;
      en_q    <= 1'b0;
      mode_q  <= 4'h0;
      ctl3_q  <= `I2CA_RST_BYTE;
      mask_q  <= `I2CA_RST_MASK;
      pie_q   <= 1'b0;
      bie_q   <= 1'b0;
      ackdt_q <= 1'b0;
    end else begin
      if (wr & (a == `I2CA_OFF_BAUD)) baud_q <= PWDATA[7:0];
      if (wr_c1) begin
        en_q   <= PWDATA[`I2CA_B_EN];
        mode_q <= PWDATA[3:0];
      end
      if (wr_c2) ackdt_q <= PWDATA[`I2CA_B_ACKDT];
      if (wr & (a == `I2CA_OFF_CTL3)) ctl3_q <= PWDATA[7:0];
      if (wr & (a == `I2CA_OFF_MASK)) mask_q <= PWDATA[7:0];
      if (wr & (a == `I2CA_OFF_IEN1)) pie_q <= PWDATA[`I2CA_B_IRQ];
      if (wr & (a == `I2CA_OFF_IEN2)) bie_q <= PWDATA[`I2CA_B_IRQ];
    end
  end

  // ========================================================================
  // collision detection per state
  always @* begin
    coll_d = 1'b0;
    case (st_q)
      ST_IDLE:   coll_d = master & sen_q & (~sda | ~scl);
      ST_S_WAIT: coll_d = sda & ~scl;
      ST_R_HIGH: coll_d = scl & ~sda;
      ST_R_HOLD: coll_d = ~scl & ~SDA_OE;
      ST_P_HIGH: coll_d = seen_q & ~scl;
      ST_P_REL:  coll_d = ~sda & (tick | ~scl);
      ST_T_HIGH: coll_d = ~SDA_OE & scl & ~sda & (idx_q != `I2CA_ACK_BIT);
      ST_A_HIGH: coll_d = ~SDA_OE & scl & ~sda;
      default:   coll_d = 1'b0;
    endcase
  end

  // ========================================================================
  // sequencer, flags and slave receiver; later assignments win
  always @(posedge CLK) begin
    if (SRST) begin
      st_q <= ST_IDLE;
      SCL_OE <= 1'b0;
      SDA_OE <= 1'b0;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      {sen_q, restart_seq_enable_q, pen_q, ack_seq_enable_q} <= 4'h0;
      {bf_q, stop_q, start_q, write_collision_flag_q, ackstat_q} <= 5'h00;
      {pif_q, bcl_q, seen_q, sfirst_q, sact_q} <= 5'h00;
      {scl_p_q, sda_p_q} <= 2'b11;
      buf_q <= `I2CA_RST_BYTE;
      sh_q <= `I2CA_RST_BYTE;
      ssh_q <= `I2CA_RST_BYTE;
      cnt_q <= `I2CA_RST_BYTE;
      idx_q <= 4'h0;
      sbit_q <= 4'h0;
      PORT_IRQ <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      // interrupt and wake outputs
      PORT_IRQ <= (pif_q & pie_q) | (bcl_q & bie_q);
      WAKE <= SLEEP & pif_q & pie_q;
      // software writes; hardware sets below override
      if (wr_f1) pif_q <= PWDATA[`I2CA_B_IRQ];
      if (wr_f2) bcl_q <= PWDATA[`I2CA_B_IRQ];
      if (wr_c1) write_collision_flag_q <= PWDATA[`I2CA_B_WRITE_COLLISION_FLAG];
      if (wr_c2) begin
        ack_seq_enable_q <= PWDATA[`I2CA_B_ACK_SEQ_ENABLE];
        pen_q   <= PWDATA[`I2CA_B_PEN];
        restart_seq_enable_q  <= PWDATA[`I2CA_B_RESTART_SEQ_ENABLE];
        sen_q   <= PWDATA[`I2CA_B_SEN];
      end
      if (rd_buf & ~master) bf_q <= 1'b0;
      if (wr_buf) begin
        if (st_q != ST_IDLE) write_collision_flag_q <= 1'b1;
        else buf_q <= PWDATA[7:0];
      end
      if (cnt_q != `I2CA_RST_BYTE) cnt_q <= cnt_q - 8'h01;
      // bus busy / free tracking
      if (start_det) begin
        start_q <= 1'b1;
        stop_q  <= 1'b0;
      end
      if (stop_det) begin
        stop_q  <= 1'b1;
        start_q <= 1'b0;
        if (start_q & ~own_stop) pif_q <= 1'b1;
      end
      if (~en_q) begin
        // disabled port: abandon everything
        st_q <= ST_IDLE;
        SCL_OE <= 1'b0;
        SDA_OE <= 1'b0;
        {sen_q, restart_seq_enable_q, pen_q, ack_seq_enable_q} <= 4'h0;
        {bf_q, stop_q, start_q, sact_q} <= 4'h0;
      end else if (~master) begin
        // slave receive, runs in sleep too
        if (start_det) begin
          sbit_q <= 4'h0;
          sfirst_q <= 1'b1;
          sact_q <= 1'b1;
        end else if (stop_det) begin
          sact_q <= 1'b0;
        end else if (sact_q & scl_rise) begin
          if (sbit_q != `I2CA_ACK_BIT) begin
            ssh_q <= {ssh_q[6:0], sda};
            sbit_q <= sbit_q + 4'h1;
          end else begin
            sbit_q <= 4'h0;
            sfirst_q <= 1'b0;
            if (sfirst_q) begin
              sact_q <= addr_hit;
              if (addr_hit) pif_q <= 1'b1;
            end else begin
              buf_q <= ssh_q;
              bf_q <= 1'b1;
              pif_q <= 1'b1;
            end
          end
        end
      end else if (coll_d) begin
        // lost arbitration: release and go idle
        bcl_q <= 1'b1;
        st_q <= ST_IDLE;
        SCL_OE <= 1'b0;
        SDA_OE <= 1'b0;
        bf_q <= 1'b0;
        {sen_q, restart_seq_enable_q, pen_q, ack_seq_enable_q} <= 4'h0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (sen_q) begin
              cnt_q <= baud_q;
              st_q <= ST_S_WAIT;
            end else if (restart_seq_enable_q) begin
              SDA_OE <= 1'b0;
              SCL_OE <= 1'b1;
              cnt_q <= baud_q;
              st_q <= ST_R_LOW;
            end else if (pen_q) begin
              SDA_OE <= 1'b1;
              SCL_OE <= 1'b1;
              seen_q <= 1'b0;
              st_q <= ST_P_LOW;
            end else if (ack_seq_enable_q) begin
              SDA_OE <= ~ackdt_q;
              SCL_OE <= 1'b1;
              cnt_q <= baud_q;
              st_q <= ST_A_LOW;
            end else if (wr_buf) begin
              sh_q <= PWDATA[7:0];
              idx_q <= 4'h0;
              bf_q <= 1'b1;
              SCL_OE <= 1'b1;
              SDA_OE <= ~PWDATA[7];
              cnt_q <= baud_q;
              st_q <= ST_T_LOW;
            end
          end
          ST_S_WAIT: begin
            if (~sda | tick) begin
              SDA_OE <= 1'b1;
              cnt_q <= baud_q;
              st_q <= ST_S_HOLD;
            end
          end
          ST_S_HOLD: begin
            if (tick) begin
              SCL_OE <= 1'b1;
              sen_q <= 1'b0;
              restart_seq_enable_q <= 1'b0;
              pif_q <= 1'b1;
              st_q <= ST_IDLE;
            end
          end
          ST_R_LOW: begin
            if (tick) begin
              SCL_OE <= 1'b0;
              st_q <= ST_R_HIGH;
            end
          end
          ST_R_HIGH: begin
            if (scl) begin
              cnt_q <= baud_q;
              st_q <= ST_R_HOLD;
            end
          end
          ST_R_HOLD: begin
            if (tick) begin
              SDA_OE <= 1'b1;
              cnt_q <= baud_q;
              st_q <= ST_S_HOLD;
            end
          end
          ST_P_LOW: begin
            if (~sda & ~seen_q) begin
              seen_q <= 1'b1;
              cnt_q <= baud_q;
            end else if (seen_q & tick) begin
              SCL_OE <= 1'b0;
              seen_q <= 1'b0;
              st_q <= ST_P_HIGH;
            end
          end
          ST_P_HIGH: begin
            if (scl & ~seen_q) begin
              seen_q <= 1'b1;
              cnt_q <= baud_q;
            end else if (seen_q & tick) begin
              SDA_OE <= 1'b0;
              seen_q <= 1'b0;
              cnt_q <= baud_q;
              st_q <= ST_P_REL;
            end
          end
          ST_P_REL: begin
            if (tick) begin
              cnt_q <= baud_q;
              st_q <= ST_P_END;
            end
          end
          ST_P_END: begin
            if (tick) begin
              pen_q <= 1'b0;
              pif_q <= 1'b1;
              st_q <= ST_IDLE;
            end
          end
          ST_T_LOW, ST_A_LOW: begin
            if (tick) begin
              SCL_OE <= 1'b0;
              seen_q <= 1'b0;
              st_q <= (st_q == ST_T_LOW) ? ST_T_HIGH : ST_A_HIGH;
            end
          end
          ST_T_HIGH: begin
            if (scl & ~seen_q) begin
              seen_q <= 1'b1;
              cnt_q <= baud_q;
            end else if (seen_q & tick) begin
              SCL_OE <= 1'b1;
              if (idx_q == `I2CA_ACK_BIT) begin
                ackstat_q <= sda;
                bf_q <= 1'b0;
                pif_q <= 1'b1;
                SDA_OE <= 1'b0;
                st_q <= ST_IDLE;
              end else begin
                idx_q <= idx_q + 4'h1;
                sh_q <= {sh_q[6:0], 1'b0};
                SDA_OE <= (idx_q == 4'h7) ? 1'b0 : ~sh_q[6];
                cnt_q <= baud_q;
                st_q <= ST_T_LOW;
              end
            end
          end
          ST_A_HIGH: begin
            if (scl & ~seen_q) begin
              seen_q <= 1'b1;
              cnt_q <= baud_q;
            end else if (seen_q & tick) begin
              SCL_OE <= 1'b1;
              SDA_OE <= 1'b0;
              ack_seq_enable_q <= 1'b0;
              pif_q <= 1'b1;
              st_q <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### i2ca_arb_chk.sv
/*
  Port checker of the i2c arbitration block: apb timing, reset, start refusal,
  sticky interrupt, wake. Assumes it is bound to i2ca_top with its AW parameter.
*/
`default_nettype none
`include "i2ca_consts.vh"

// ==========================================================================
// port checker
module i2ca_arb_chk #(
  parameter AW = 8
) (
  // clock and reset
  input wire logic          CLK,
  input wire logic          SRST,
  // apb
  input wire logic          PSEL,
  input wire logic          PENABLE,
  input wire logic          PWRITE,
  input wire logic [AW-1:0] PADDR,
  input wire logic [31:0]   PWDATA,
  input wire logic [31:0]   PRDATA,
  input wire logic          PREADY,
  input wire logic          PSLVERR,
  // i2c pins
  input wire logic          SCL_IN,
  input wire logic          SCL_OUT,
  input wire logic          SCL_OE,
  input wire logic          SDA_IN,
  input wire logic          SDA_OUT,
  input wire logic          SDA_OE,
  // system
  input wire logic          SLEEP,
  input wire logic          PORT_IRQ,
  input wire logic          WAKE
);
  logic apb_wr;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  // write access phase
  assign apb_wr = PSEL & PENABLE & PWRITE;

  // apb answer timing
  AST_READY_AFTER_SETUP: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  AST_READY_ONE_CYCLE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  AST_UNMAPPED: assert property (PSEL && !PENABLE && PADDR[7:0] > 8'h28 |=> PSLVERR)
    else $error("unmapped access not refused");
  AST_RDATA_QUIET: assert property (!PREADY |-> PRDATA == 32'h00000000)
    else $error("read data outside access");
  AST_PIN_LEVELS: assert property (!SDA_OUT && !SCL_OUT)
    else $error("open-drain output level not low");
  // reset releases the bus and quiets outputs
  AST_RESET_RELEASE: assert property (@(posedge CLK) disable iff (1'b0)
    SRST |=> !SDA_OE && !SCL_OE && !PORT_IRQ && !WAKE && !PREADY)
    else $error("outputs active after reset");
  // start with a line already low does not drive the bus for 8 cycles
  AST_START_LOW: assert property (apb_wr && PADDR[7:0] == `I2CA_OFF_CTL2 &&
    PWDATA[0] && !SDA_OE && !SCL_OE &&
    ((!SDA_IN && !$past(SDA_IN, 4)) || (!SCL_IN && !$past(SCL_IN, 4)))
    |=> (!SDA_OE && !SCL_OE) [*8])
    else $error("start drove a busy bus");
  // flags only fall by a software write
  AST_IRQ_STICKY: assert property (PORT_IRQ && !apb_wr && !$past(apb_wr)
    |=> PORT_IRQ)
    else $error("interrupt fell without a write");
  AST_WAKE_IRQ: assert property (WAKE |-> PORT_IRQ)
    else $error("wake without port interrupt");
  AST_WAKE_SLEEP: assert property (!SLEEP |=> !WAKE)
    else $error("wake while awake");

  // main scenarios seen
  COV_REFUSED: cover property (PSLVERR);
  COV_WAKE: cover property (WAKE);
  COV_IRQ: cover property ($rose(PORT_IRQ));
  COV_RELEASE: cover property ($fell(SDA_OE) && SCL_IN);
endmodule

bind i2ca_top i2ca_arb_chk #(.AW(AW)) u_chk (
  .CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SLEEP(SLEEP),
  .PORT_IRQ(PORT_IRQ), .WAKE(WAKE)
);
`default_nettype wire

// ### i2ca_peer.sv
/*
  Far side of the bus: pull-ups, a party that can hold either line low, and
  a master sending two-byte frames at a 400 ns bit period.
  Assumes the block pulls its pins low through active-high enables.
*/
`default_nettype none

// ==========================================================================
// open-drain bus and far-side party
module i2ca_peer (
  // block pull-down enables
  input  wire logic sda_oe,
  input  wire logic scl_oe,
  // holds commanded by the bench
  input  wire logic hold_sda,
  input  wire logic hold_scl,
  // resolved wire levels
  output wire logic sda_ln,
  output wire logic scl_ln
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       p_sda = 1'b0;
  logic       p_scl = 1'b0;
  logic [8:0] sh    = 9'h1FF;

  // wired-and with pull-ups, any enable pulls low
  assign sda_ln = !(sda_oe | p_sda | hold_sda);
  assign scl_ln = !(scl_oe | p_scl | hold_scl);

  // last nine data bits seen at clock rises
  always @(posedge scl_ln) begin
    sh <= {sh[7:0], sda_ln};
  end

  // one bit: data set while clock low
  task automatic bit_out(input logic b);
    p_sda = !b;
    #100;
    p_scl = 1'b0;
    #200;
    p_scl = 1'b1;
    #100;
  endtask

  // msb first, then a released ack bit
  task automatic byte_out(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i]);
    end
    bit_out(1'b1);
  endtask

  // start, address byte, data byte, stop
  task automatic frame(input logic [7:0] adr, input logic [7:0] dat);
    p_sda = 1'b1;
    #200;
    p_scl = 1'b1;
    byte_out(adr);
    byte_out(dat);
    p_sda = 1'b1;
    #100;
    p_scl = 1'b0;
    #200;
    p_sda = 1'b0;
    #200;
  endtask
endmodule
`default_nettype wire

// ### test_i2c_master_bus_arbitration.sv
/*
  Self-checking bench of the i2c arbitration block: apb tasks, far-side peer,
  expected bytes kept in a queue. Assumes a 20 MHz clock, reset held 5 cycles.
*/
`default_nettype none
`include "i2ca_consts.vh"

// ==========================================================================
// bench top
module test_i2c_master_bus_arbitration;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, psel, penable, pwrite, sleep, hold_sda, hold_scl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic        pready, pslverr, rd_err, scl_in, scl_out, scl_oe;
  logic        sda_in, sda_out, sda_oe, port_irq, wake;
  logic [7:0]  tx, adr;
  logic [7:0]  exp_q[$];
  int          failures = 0;
  int          n_checks = 0;

  i2ca_top dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCL_IN(scl_in), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_in),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SLEEP(sleep), .PORT_IRQ(port_irq), .WAKE(wake));
  i2ca_peer peer (.sda_oe(sda_oe), .scl_oe(scl_oe), .hold_sda(hold_sda),
    .hold_scl(hold_scl), .sda_ln(sda_in), .scl_ln(scl_in));

  // 50 ns clock
  always #25 clk = ~clk;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // setup, access until ready, then release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) failures++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_data & m, e);
  endtask

  // poll until the masked bits are set
  task automatic wait_set(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd_data & m) !== m && n < 300);
    chk(rd_data & m, m);
  endtask

  task automatic start_seq;
    wr(`I2CA_OFF_CTL2, 32'h01);
    wait_set(`I2CA_OFF_IFL1, 32'h08);
    wr(`I2CA_OFF_IFL1, 32'h00);
  endtask

  // hang guard, about 20000 cycles
  initial begin
    #1000000;
    failures++;
    finish_test();
  end

  // main sequence
  initial begin
    {clk, psel, penable, pwrite, sleep, hold_sda, hold_scl} = 7'h00;
    srst = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    void'($urandom(53530));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      rdm(8'(i * 4), 32'hFFFFFFFF, (i == 5) ? 32'hFF : 32'h0);
    end
    apb(1'b0, 8'h2C, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    $display("test reset values done");
    // master start, then lose arbitration on the first byte
    wr(`I2CA_OFF_BAUD, 32'h04);
    wr(`I2CA_OFF_IEN2, 32'h08);
    wr(`I2CA_OFF_CTL1, 32'h28);
    rdm(`I2CA_OFF_STAT, 32'h18, 32'h00);
    start_seq();
    rdm(`I2CA_OFF_CTL2, 32'h01, 32'h00);
    chk({30'h0, sda_oe, scl_oe}, 32'h3);
    hold_sda <= 1'b1;
    wr(`I2CA_OFF_BUF, 32'hFF);
    wait_set(`I2CA_OFF_IFL2, 32'h08);
    rdm(`I2CA_OFF_STAT, 32'h01, 32'h00);
    chk({30'h0, sda_oe, scl_oe}, 32'h0);
    chk({31'h0, port_irq}, 32'h1);
    repeat (4) @(posedge clk);
    hold_sda <= 1'b0;
    wait_set(`I2CA_OFF_IFL1, 32'h08);
    wr(`I2CA_OFF_IFL2, 32'h00);
    wr(`I2CA_OFF_IFL1, 32'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, port_irq}, 32'h0);
    $display("test byte collision done");
    // fresh byte after collision goes out from its msb
    tx = 8'($urandom);
    exp_q.push_back(tx);
    start_seq();
    wr(`I2CA_OFF_BUF, {24'h0, tx});
    wait_set(`I2CA_OFF_IFL1, 32'h08);
    chk({23'h0, peer.sh}, {23'h0, exp_q.pop_front(), 1'b1});
    // stop with a buffer write in the middle
    wr(`I2CA_OFF_IFL1, 32'h00);
    wr(`I2CA_OFF_CTL2, 32'h04);
    wr(`I2CA_OFF_BUF, {24'h0, ~tx});
    rdm(`I2CA_OFF_CTL1, 32'h80, 32'h80);
    wait_set(`I2CA_OFF_IFL1, 32'h08);
    rdm(`I2CA_OFF_CTL2, 32'h04, 32'h00);
    rdm(`I2CA_OFF_STAT, 32'h10, 32'h10);
    rdm(`I2CA_OFF_BUF, 32'hFF, {24'h0, tx});
    $display("test stop done");
    // start refused with either line already low
    wr(`I2CA_OFF_CTL1, 32'h28);
    for (int k = 0; k < 2; k++) begin
      hold_sda <= (k == 0);
      hold_scl <= (k == 1);
      repeat (6) @(posedge clk);
      wr(`I2CA_OFF_CTL2, 32'h01);
      wait_set(`I2CA_OFF_IFL2, 32'h08);
      rdm(`I2CA_OFF_CTL2, 32'h01, 32'h00);
      chk({30'h0, sda_oe, scl_oe}, 32'h0);
      hold_sda <= 1'b0;
      hold_scl <= 1'b0;
      repeat (4) @(posedge clk);
      wr(`I2CA_OFF_IFL2, 32'h00);
      wr(`I2CA_OFF_IFL1, 32'h00);
    end
    wr(`I2CA_OFF_CTL1, 32'h08);
    rdm(`I2CA_OFF_STAT, 32'h18, 32'h00);
    $display("test busy start and disable done");
    // slave in sleep: wrong address first, then a match
    wr(`I2CA_OFF_BAUD, 32'hA4);
    wr(`I2CA_OFF_IEN1, 32'h08);
    wr(`I2CA_OFF_CTL1, 32'h26);
    sleep <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      adr = (j == 1) ? 8'hA4 : (8'hA4 ^ 8'(2 << ($urandom % 7)));
      tx = 8'($urandom);
      peer.frame(adr, tx);
      repeat (4) @(posedge clk);
      chk({31'h0, wake}, 32'h1);
      rdm(`I2CA_OFF_STAT, 32'h01, 32'(j));
      if (j == 0) wr(`I2CA_OFF_IFL1, 32'h00);
    end
    rdm(`I2CA_OFF_STAT, 32'h01, 32'h01);
    rdm(`I2CA_OFF_BUF, 32'hFF, {24'h0, tx});
    sleep <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, wake}, 32'h0);
    $display("test sleep wake done");
    finish_test();
  end
endmodule
`default_nettype wire
